// ### design/vds_drive_top.sv
// vibration drive: source select, actuator scaling, frequency and soft release
//
// The register addresses and the APB slave port were left to the implementer.
`default_nettype none
module vds_drive_top import vds_pkg::*; #(
    parameter int MS_CYCLES = MS_NS / CLK_PERIOD_NS
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire vds_fb_t fbCmd,
    output vds_drv_t drive,
    output logic [13:0] driveFreq,
    output logic backlightEn,
    output logic actuatorEn,
    output logic softActive
);
    function automatic logic [9:0] scale(input logic [9:0] lvl, input logic [9:0] mx);
        logic [19:0] p;
        p = lvl * mx;
        scale = 10'(p / 20'(LVL_FULL));
    endfunction : scale

    function automatic logic [9:0] ratio(input logic [9:0] a, input logic [9:0] b,
                                         input logic [9:0] c);
        logic [19:0] q;
        q = (c == 10'h000) ? 20'(a) : (a * b) / 20'(c);
        ratio = (q > 20'(LVL_FULL)) ? LVL_FULL : 10'(q);
    endfunction : ratio

    function automatic logic [9:0] clampLvl(input logic [31:0] d);
        clampLvl = (d > 32'(LVL_FULL)) ? LVL_FULL : d[9:0];
    endfunction : clampLvl

    function automatic logic isMapped(input logic [7:0] a);
        isMapped = (a <= A_PSET) && (a[1:0] == 2'h0);
    endfunction : isMapped

    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;
    logic [3:0] ctrl_r;
    logic [9:0] manInt_r;
    logic [9:0] vmax_r;
    logic [9:0] dmax_r;
    logic [13:0] freq_r;
    logic [9:0] hold_r;
    logic [15:0] holdMs_r;
    logic [15:0] relMs_r;
    logic [9:0] fbLvl_r;
    logic fbRel_r;
    logic [1:0] lastSet_r;
    vds_pset_t pset_r [NSETS];
    vds_sr_t srState_r;
    logic [15:0] cnt_r;
    logic [31:0] msDiv_r;
    logic [9:0] prevLvl_r;
    logic [9:0] envLvl;
    vds_drv_t drive_r;
    logic [13:0] driveFreq_r;
    logic backlightEn_r;
    logic actuatorEn_r;
    logic softActive_r;
    logic wrEn;
    logic [9:0] wLvl;
    logic [13:0] fUp;
    logic [13:0] fDn;
    logic manual;
    logic released;
    logic [9:0] cmdLvl;
    logic [9:0] baseLvl;
    logic fallEdge;
    logic srStart;
    logic msTick;
    logic [31:0] rdMux;

    assign wrEn = psel && penable && pready_r && pwrite;
    assign wLvl = clampLvl(pwdata);
    assign manual = ctrl_r[CB_MANUAL];
    // manual takes register values, automatic takes the latched fieldbus command
    assign released = manual ? ctrl_r[CB_REL] : fbRel_r;
    assign cmdLvl = !released ? 10'h000 : (manual ? manInt_r : fbLvl_r);
    assign fallEdge = (prevLvl_r != 10'h000) && (cmdLvl == 10'h000);
    assign srStart = (srState_r == SR_IDLE) && fallEdge && released && ctrl_r[CB_SREN]
                     && (holdMs_r != 16'h0000 || relMs_r != 16'h0000);
    assign msTick = (msDiv_r == 32'(MS_CYCLES - 1));

    // apb slave: answer prepared in setup, zero wait states
    always_comb begin
        rdMux = 32'h0000_0000;
        case (paddr)
            A_CTRL: rdMux = {28'h000_0000, ctrl_r};
            A_MANINT: rdMux = {22'h00_0000, manInt_r};
            A_VMAX: rdMux = {22'h00_0000, vmax_r};
            A_DMAX: rdMux = {22'h00_0000, dmax_r};
            A_FREQ: rdMux = {18'h0_0000, freq_r};
            A_HOLD: rdMux = {22'h00_0000, hold_r};
            A_HOLDT: rdMux = {16'h0000, holdMs_r};
            A_RELT: rdMux = {16'h0000, relMs_r};
            A_STAT: begin
                rdMux[9:0] = baseLvl;
                rdMux[ST_SRACT] = softActive_r;
                rdMux[ST_SRACT+2 -: 2] = srState_r;
                rdMux[ST_REL] = released;
                rdMux[ST_MAN] = manual;
            end
            A_PSET: rdMux = {30'h0000_0000, lastSet_r};
            default: rdMux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            prdata_r <= 32'h0000_0000;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            pready_r <= psel && !penable;
            pslverr_r <= psel && !penable && !isMapped(paddr);
            if (psel && !penable) begin
                prdata_r <= isMapped(paddr) ? rdMux : 32'h0000_0000;
            end
        end
    end

    // frequency step sizes: fine when pwdata[1] is set, else coarse
    assign fUp = (pwdata[1] ? STEP_FINE : STEP_COARSE);
    assign fDn = (pwdata[1] ? STEP_FINE : STEP_COARSE);

    // configuration registers and parameter sets
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            ctrl_r <= 4'h0;
            manInt_r <= 10'h000;
            vmax_r <= LVL_FULL;
            dmax_r <= LVL_FULL;
            freq_r <= FREQ_RST;
            hold_r <= 10'h000;
            holdMs_r <= 16'h0000;
            relMs_r <= 16'h0000;
            lastSet_r <= 2'h0;
        end else if (wrEn && isMapped(paddr)) begin
            case (paddr)
                A_CTRL: ctrl_r <= pwdata[3:0];
                A_MANINT: manInt_r <= wLvl;
                A_VMAX: begin
                    vmax_r <= wLvl;
                    if (ctrl_r[CB_LOCK]) begin
                        dmax_r <= ratio(dmax_r, wLvl, vmax_r);
                    end
                end
                A_DMAX: begin
                    dmax_r <= wLvl;
                    if (ctrl_r[CB_LOCK]) begin
                        vmax_r <= ratio(vmax_r, wLvl, dmax_r);
                    end
                end
                A_FREQ: begin
                    if (pwdata[13:0] < FREQ_MIN) begin
                        freq_r <= FREQ_MIN;
                    end else if (pwdata[13:0] > FREQ_MAX || pwdata[31:14] != 18'h0_0000) begin
                        freq_r <= FREQ_MAX;
                    end else begin
                        freq_r <= pwdata[13:0];
                    end
                end
                A_FSTEP: begin
                    if (pwdata[1:0] == FS_UP_C || pwdata[1:0] == FS_UP_F) begin
                        freq_r <= (freq_r > FREQ_MAX - fUp) ? FREQ_MAX : freq_r + fUp;
                    end else begin
                        freq_r <= (freq_r < FREQ_MIN + fDn) ? FREQ_MIN : freq_r - fDn;
                    end
                end
                A_HOLD: hold_r <= wLvl;
                A_HOLDT: holdMs_r <= pwdata[15:0];
                A_RELT: relMs_r <= pwdata[15:0];
                A_PSET: begin
                    lastSet_r <= pwdata[PS_IDX +: SET_W];
                    if (pwdata[PS_LOAD]) begin
                        vmax_r <= pset_r[pwdata[PS_IDX +: SET_W]].vmax;
                        dmax_r <= pset_r[pwdata[PS_IDX +: SET_W]].dmax;
                        freq_r <= pset_r[pwdata[PS_IDX +: SET_W]].freq;
                        ctrl_r[CB_SREN] <= pset_r[pwdata[PS_IDX +: SET_W]].srEn;
                        hold_r <= pset_r[pwdata[PS_IDX +: SET_W]].hold;
                        holdMs_r <= pset_r[pwdata[PS_IDX +: SET_W]].holdMs;
                        relMs_r <= pset_r[pwdata[PS_IDX +: SET_W]].relMs;
                    end
                end
                default: ;
            endcase
        end
    end

    // stored sets start as the reset configuration
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            for (int i = 0; i < NSETS; i++) begin
                pset_r[i] <= '{LVL_FULL, LVL_FULL, FREQ_RST, 1'b0, 10'h000, 16'h0000, 16'h0000};
            end
        end else if (wrEn && paddr == A_PSET && pwdata[PS_STORE]) begin
            pset_r[pwdata[PS_IDX +: SET_W]] <= '{vmax_r, dmax_r, freq_r, ctrl_r[CB_SREN],
                                                hold_r, holdMs_r, relMs_r};
        end
    end

    // fieldbus latch; blocked while manual, so a later switch back resumes the last order taken before manual
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            fbLvl_r <= 10'h000;
            fbRel_r <= 1'b0;
        end else if (fbCmd.valid && !manual) begin
            fbLvl_r <= (fbCmd.level > LVL_FULL) ? LVL_FULL : fbCmd.level;
            fbRel_r <= fbCmd.release_;
        end
    end

    // millisecond enable, restarted per envelope so the first hold tick is whole
    always_ff @(posedge sys_clk) begin
        if (!reset_n || srState_r == SR_IDLE || msTick) begin
            msDiv_r <= 32'h0000_0000;
        end else begin
            msDiv_r <= msDiv_r + 32'h0000_0001;
        end
    end

    // soft release envelope
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            srState_r <= SR_IDLE;
            cnt_r <= 16'h0000;
            prevLvl_r <= 10'h000;
        end else begin
            prevLvl_r <= cmdLvl;
            case (srState_r)
                SR_IDLE: begin
                    if (fallEdge && released && ctrl_r[CB_SREN]) begin
                        if (holdMs_r != 16'h0000) begin
                            srState_r <= SR_HOLD;
                            cnt_r <= holdMs_r;
                        end else if (relMs_r != 16'h0000) begin
                            srState_r <= SR_RAMP;
                            cnt_r <= relMs_r;
                        end
                    end
                end
                SR_HOLD: begin
                    if (!released || cmdLvl != 10'h000) begin
                        srState_r <= SR_IDLE;
                    end else if (msTick && cnt_r == 16'h0001) begin
                        srState_r <= (relMs_r != 16'h0000) ? SR_RAMP : SR_IDLE;
                        cnt_r <= relMs_r;
                    end else if (msTick) begin
                        cnt_r <= cnt_r - 16'h0001;
                    end
                end
                SR_RAMP: begin
                    if (!released || cmdLvl != 10'h000) begin
                        srState_r <= SR_IDLE;
                    end else if (msTick && cnt_r == 16'h0001) begin
                        srState_r <= SR_IDLE;
                        cnt_r <= 16'h0000;
                    end else if (msTick) begin
                        cnt_r <= cnt_r - 16'h0001;
                    end
                end
                default: srState_r <= SR_IDLE;
            endcase
        end
    end

    // linear ramp from the hold level: remaining ms over the whole release time
    assign envLvl = (srState_r == SR_HOLD) ? hold_r :
                    (srState_r == SR_RAMP) ? ratio(hold_r, cnt_r[9:0], relMs_r[9:0]) :
                    10'h000;
    // start shows the hold level at once, so the fall never cuts drive for a cycle
    assign baseLvl = (srState_r != SR_IDLE && cmdLvl == 10'h000) ? envLvl :
                     (srStart ? hold_r : cmdLvl);

    // outputs: both actuator groups from one base level in the same cycle
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            drive_r <= '0;
            driveFreq_r <= FREQ_RST;
            backlightEn_r <= 1'b0;
            actuatorEn_r <= 1'b0;
            softActive_r <= 1'b0;
        end else begin
            drive_r.vert <= released ? scale(baseLvl, vmax_r) : 10'h000;
            drive_r.damp <= released ? scale(baseLvl, dmax_r) : 10'h000;
            driveFreq_r <= freq_r;
            backlightEn_r <= released;
            actuatorEn_r <= released;
            softActive_r <= ctrl_r[CB_SREN];
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign drive = drive_r;
    assign driveFreq = driveFreq_r;
    assign backlightEn = backlightEn_r;
    assign actuatorEn = actuatorEn_r;
    assign softActive = softActive_r;

    default clocking dc @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    a_manual_fb_blocked: assert property (manual |=> $stable(fbLvl_r) && $stable(fbRel_r))
        else $error("fieldbus command taken in manual mode");
    a_release_all_off: assert property (!released |=> drive_r == '0
                                        && !backlightEn_r && !actuatorEn_r)
        else $error("outputs on without general release");
    a_src_manual: assert property (manual && released && srState_r == SR_IDLE
                                   && !srStart |=> drive_r.vert == scale($past(manInt_r),
                                   $past(vmax_r)))
        else $error("manual drive not from register setpoint");
    a_scale_both: assert property (released && srState_r == SR_IDLE && !srStart
                                   |=> drive_r.vert == scale($past(cmdLvl), $past(vmax_r))
                                   && drive_r.damp == scale($past(cmdLvl), $past(dmax_r)))
        else $error("actuator scaling wrong");
    a_sr_start: assert property (srState_r == SR_IDLE && fallEdge && released
                                 && ctrl_r[CB_SREN] && holdMs_r != 16'h0000
                                 |=> srState_r == SR_HOLD)
        else $error("soft release did not start");
    a_sr_no_cut: assert property (srStart
                                  |=> drive_r.vert == scale($past(hold_r), $past(vmax_r)))
        else $error("drive cut at soft release start");
    a_sr_cut: assert property (srState_r == SR_IDLE && fallEdge && !ctrl_r[CB_SREN]
                               |=> drive_r == '0)
        else $error("drive not cut with soft release off");
    a_hold_level: assert property (srState_r == SR_HOLD && released && cmdLvl == 10'h000
                                   |=> drive_r.vert == scale($past(hold_r), $past(vmax_r)))
        else $error("hold level not driven");
    a_ramp_falls: assert property (srState_r == SR_RAMP ##1 srState_r == SR_RAMP
                                   && $stable(hold_r) |-> envLvl <= $past(envLvl))
        else $error("ramp level rose");
    a_abort_env: assert property (srState_r != SR_IDLE && cmdLvl != 10'h000
                                  |=> srState_r == SR_IDLE)
        else $error("envelope not aborted");
    a_lock_ratio: assert property (wrEn && paddr == A_VMAX && ctrl_r[CB_LOCK]
                                   |=> dmax_r == ratio($past(dmax_r), $past(wLvl),
                                   $past(vmax_r)))
        else $error("locked ratio not kept");
    a_freq_range: assert property (freq_r >= FREQ_MIN && freq_r <= FREQ_MAX)
        else $error("frequency out of range");
    a_apb_answer: assert property (psel && !penable |=> pready_r ##1 !pready_r)
        else $error("apb answer timing wrong");

    c_hold_to_ramp: cover property (srState_r == SR_HOLD ##1 srState_r == SR_RAMP);
    c_ramp_done: cover property (srState_r == SR_RAMP ##1 srState_r == SR_IDLE);
    c_abort: cover property (srState_r != SR_IDLE && cmdLvl != 10'h000);
    c_set_load: cover property (wrEn && paddr == A_PSET && pwdata[PS_LOAD]);
endmodule : vds_drive_top
`default_nettype wire

// ### design/vds_pkg.sv
// constants, types and register map of the vibration drive with soft release
// Overview of operation
// - Manual mode takes the intensity from the register, automatic mode from the fieldbus.
// - Damping drive is the 0-100% intensity scaled linearly onto zero to the damping maximum.
// - Damping and vertical drives are updated together from one intensity value.
// - Vertical drive is the intensity scaled linearly onto zero to the vertical maximum.
// - With ratio lock on, writing one maximum rescales the other by the same proportion.
// - Oscillation frequency is held and stepped up or down in coarse and fine steps.
// - With soft release on, a fall of the intensity to zero starts the envelope instead of cutting drive.
// - The envelope first drives the hold level for the hold time.
// - After the hold the drive ramps linearly to zero over the release time, then stays off.
// - Soft release has an enable bit and a readable active flag.
// - Enable, hold level, hold time and release time are stored and loaded with each set.
// - With general release at zero every power output, backlight included, is off.
// - In manual mode fieldbus commands are ignored.
`default_nettype none
package vds_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_MANINT = 8'h04;
    localparam logic [7:0] A_VMAX = 8'h08;
    localparam logic [7:0] A_DMAX = 8'h0C;
    localparam logic [7:0] A_FREQ = 8'h10;
    localparam logic [7:0] A_FSTEP = 8'h14;
    localparam logic [7:0] A_HOLD = 8'h18;
    localparam logic [7:0] A_HOLDT = 8'h1C;
    localparam logic [7:0] A_RELT = 8'h20;
    localparam logic [7:0] A_STAT = 8'h24;
    localparam logic [7:0] A_PSET = 8'h28;
    localparam int CB_MANUAL = 0;
    localparam int CB_REL = 1;
    localparam int CB_SREN = 2;
    localparam int CB_LOCK = 3;
    localparam int LVL_W = 10;
    localparam logic [9:0] LVL_FULL = 10'h3E8;
    localparam int FREQ_W = 14;
    localparam logic [13:0] FREQ_MIN = 14'h000A;
    localparam logic [13:0] FREQ_MAX = 14'h07D0;
    localparam logic [13:0] FREQ_RST = 14'h01AE;
    localparam logic [13:0] STEP_COARSE = 14'h000A;
    localparam logic [13:0] STEP_FINE = 14'h0001;
    localparam logic [1:0] FS_UP_C = 2'h0;
    localparam logic [1:0] FS_DN_C = 2'h1;
    localparam logic [1:0] FS_UP_F = 2'h2;
    localparam logic [1:0] FS_DN_F = 2'h3;
    localparam int MS_W = 16;
    localparam int PS_STORE = 0;
    localparam int PS_LOAD = 1;
    localparam int PS_IDX = 4;
    localparam int NSETS = 4;
    localparam int SET_W = 2;
    localparam int ST_SRACT = 16;
    localparam int ST_REL = 19;
    localparam int ST_MAN = 20;
    localparam int CLK_PERIOD_NS = 50;
    localparam int MS_NS = 1000000;
    typedef enum logic [1:0] {SR_IDLE = 2'b00, SR_HOLD = 2'b01, SR_RAMP = 2'b10} vds_sr_t;
    typedef struct packed {
        logic valid;
        logic release_;
        logic [9:0] level;
    } vds_fb_t;
    typedef struct packed {
        logic [9:0] vert;
        logic [9:0] damp;
    } vds_drv_t;
    typedef struct packed {
        logic [9:0] vmax;
        logic [9:0] dmax;
        logic [13:0] freq;
        logic srEn;
        logic [9:0] hold;
        logic [15:0] holdMs;
        logic [15:0] relMs;
    } vds_pset_t;
endpackage : vds_pkg
`default_nettype wire

// ### testbench/vds_fb_model.sv
// fieldbus controller model issuing intensity orders
`default_nettype none
module vds_fb_model import vds_pkg::*; (
    input wire logic sys_clk,
    output vds_fb_t fbCmd
);
    timeunit 1ns;
    timeprecision 1ns;
    initial fbCmd = '0;
    // one-cycle strobe; lines toggle after it so stale data never looks valid
    task automatic send(input logic [9:0] lvl, input logic rel);
        @(posedge sys_clk);
        fbCmd <= '{valid: 1'b1, release_: rel, level: lvl};
        @(posedge sys_clk);
        fbCmd <= '{valid: 1'b0, release_: ~rel, level: ~lvl};
    endtask : send
endmodule : vds_fb_model
`default_nettype wire

// ### testbench/tb_top.sv
// self-checking bench of the vibration drive over apb and fieldbus
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import vds_pkg::*;
    logic sys_clk = 0;
    logic reset_n = 0;
    logic psel = 0;
    logic penable = 0;
    logic pwrite = 0;
    logic [7:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    vds_fb_t fbCmd;
    vds_drv_t drive;
    logic [13:0] driveFreq;
    logic backlightEn;
    logic actuatorEn;
    logic softActive;
    int n_errors = 0;
    int samples_checked = 0;
    logic [31:0] q;
    logic e;
    logic [13:0] f;
    int hc;
    int lv;
    bit mid;
    vds_drive_top #(.MS_CYCLES(4)) vds_drive_top_i (.sys_clk(sys_clk), .reset_n(reset_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .fbCmd(fbCmd), .drive(drive),
        .driveFreq(driveFreq), .backlightEn(backlightEn), .actuatorEn(actuatorEn),
        .softActive(softActive));
    vds_fb_model vds_fb_model_i (.sys_clk(sys_clk), .fbCmd(fbCmd));
    initial forever #25 sys_clk = ~sys_clk;
    task automatic close_out();
        $display("checks %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : close_out
    task automatic chk(input logic [31:0] g, input logic [31:0] x, input string m);
        samples_checked++;
        if (g !== x) begin
            n_errors++;
            $display("unexpected at %0t: %s got %0h want %0h", $time, m, g, x);
        end
    endtask : chk
    // setup, then access held until pready seen high; released on that edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge sys_clk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            chk(0, 1, "pready timeout");
            close_out();
        end
        q = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1, a, d);
    endtask : wr
    task automatic settle(input int n);
        repeat (n) @(posedge sys_clk);
        @(negedge sys_clk);
    endtask : settle
    task automatic drv(input int v, input int d, input string m);
        chk(32'(drive.vert), v, m);
        chk(32'(drive.damp), d, m);
    endtask : drv
    task automatic done(input string t);
        $display("test %s done", t);
    endtask : done
    initial begin
        repeat (2) @(posedge sys_clk);
        reset_n <= 1;
        settle(1);
        chk(32'(driveFreq), 32'(FREQ_RST), "freq rst");
        drv(0, 0, "drive rst");
        chk(32'(backlightEn), 0, "bl rst");
        chk(32'(softActive), 0, "sa rst");
        apb(0, A_VMAX, 0);
        chk(q, 1000, "vmax rst");
        apb(0, A_CTRL, 0);
        chk(q, 0, "ctrl rst");
        done("reset");
        vds_fb_model_i.send(10'd500, 1);
        settle(3);
        drv(500, 500, "auto");
        chk(32'(backlightEn), 1, "bl on");
        chk(32'(actuatorEn), 1, "act on");
        wr(A_DMAX, 800);
        vds_fb_model_i.send(10'd250, 1);
        settle(3);
        drv(250, 200, "auto dmax");
        vds_fb_model_i.send(10'd250, 0);
        settle(3);
        drv(0, 0, "no release");
        chk(32'({backlightEn, actuatorEn}), 0, "outs off");
        done("automatic");
        wr(A_CTRL, 32'h3);
        wr(A_MANINT, 600);
        settle(3);
        drv(600, 480, "manual");
        vds_fb_model_i.send(10'd100, 1);
        settle(3);
        drv(600, 480, "fb ignored");
        wr(A_CTRL, 32'hB);
        wr(A_VMAX, 500);
        apb(0, A_DMAX, 0);
        chk(q, 400, "lock dmax");
        settle(3);
        drv(300, 240, "locked");
        done("manual");
        f = FREQ_RST;
        for (int i = 0; i < 4; i++) begin
            wr(A_FSTEP, i);
            f = (i[0] ? f - 14'(i < 2 ? 10 : 1) : f + 14'(i < 2 ? 10 : 1));
            settle(2);
            chk(32'(driveFreq), 32'(f), "fstep");
        end
        wr(A_FREQ, 32'(FREQ_MAX));
        wr(A_FSTEP, 32'(FS_UP_C));
        settle(2);
        chk(32'(driveFreq), 32'(FREQ_MAX), "fmax");
        wr(A_FREQ, 32'(FREQ_MIN));
        wr(A_FSTEP, 32'(FS_DN_F));
        settle(2);
        chk(32'(driveFreq), 32'(FREQ_MIN), "fmin");
        done("frequency");
        wr(A_CTRL, 32'h7);
        wr(A_VMAX, 1000);
        wr(A_DMAX, 1000);
        wr(A_HOLD, 300);
        wr(A_HOLDT, 2);
        wr(A_RELT, 4);
        apb(0, A_STAT, 0);
        chk(32'(q[ST_SRACT]), 1, "sr stat");
        chk(32'(softActive), 1, "sr flag");
        wr(A_PSET, 32'h11);
        wr(A_MANINT, 600);
        wr(A_MANINT, 0);
        hc = 0;
        lv = 300;
        mid = 0;
        // hold 2 ms of 4 cycles, ramp 4 ms; first ramp step may still read the hold level
        // skip the edge that still carries the level before the fall
        @(posedge sys_clk);
        for (int n = 0; n < 80 && drive.vert !== 10'd0; n++) begin
            @(negedge sys_clk);
            if (drive.vert === 10'd300) hc++;
            if (drive.vert > 0 && drive.vert < 300) mid = 1;
            if (drive.vert > lv) chk(32'(drive.vert), lv, "ramp up");
            lv = drive.vert;
        end
        chk(32'(drive.vert), 0, "ramp end");
        chk(32'(hc >= 8 && hc <= 13), 1, "hold len");
        chk(32'(mid), 1, "linear ramp");
        wr(A_MANINT, 600);
        wr(A_MANINT, 0);
        settle(2);
        drv(300, 300, "hold lvl");
        wr(A_MANINT, 500);
        settle(3);
        drv(500, 500, "abort");
        apb(0, A_STAT, 0);
        chk(32'(q[18:17]), 0, "idle");
        wr(A_CTRL, 32'h3);
        wr(A_MANINT, 0);
        settle(3);
        drv(0, 0, "hard cut");
        chk(32'(softActive), 0, "sr off");
        done("soft release");
        wr(A_HOLD, 100);
        wr(A_PSET, 32'h12);
        apb(0, A_HOLD, 0);
        chk(q, 300, "set hold");
        apb(0, A_CTRL, 0);
        chk(32'(q[CB_SREN]), 1, "set sren");
        apb(0, A_PSET, 0);
        chk(q, 1, "set idx");
        apb(0, 8'h2C, 0);
        chk(q, 0, "unmapped data");
        chk(32'(e), 1, "unmapped err");
        apb(1, 8'h02, 32'h5);
        chk(32'(e), 1, "unaligned");
        apb(0, A_CTRL, 0);
        chk(q, 7, "unaligned ignored");
        done("sets and errors");
        close_out();
    end
endmodule : tb_top
`default_nettype wire
